//--- rtl/word_shift_rotate_unit.sv
// Top: registered 16-bit shift and rotate unit with spill and fill flags
//
// Functional notes
// - Left fill shift of full 16-bit word
// - Vacated low bits take fill bit
// - Flag holds last bit out top
// - Zero count: word and flag kept
// - Spill flag and fill bit as outputs
// - Memory amount uses low four bits
// - Immediate amount limited to 0..15
// - Rotate right through flag, 17 bits
// - Rotate left through flag, 17 bits
// - Zero rotate count keeps word, flag
// - Zero fill right shift clears top
// - Flag gets last bit shifted out
// - Zero count: word and flag kept
// - Right fill: flag gets last out
`timescale 1ns/100ps
module word_shift_rotate_unit
  import wsr_pkg::*;
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic start,
  input wire req_t req,
  input wire logic fill_we,
  input wire logic fill_wdata,
  output res_t result,
  output logic done,
  output logic amount_err,
  output logic spill_flag,
  output logic fill_bit
);

  // ****************************************
  // Count selection
  // ****************************************

  // Count and result of the core
  logic [3:0] cnt;
  logic range_bad;
  res_t core_res;

  assign cnt = req.amount[3:0];
  assign range_bad = req.imm && (req.amount[15:4] != 12'h000);

  // ****************************************
  // Datapath
  // ****************************************

  wsr_core u_core (
    .op(req.op),
    .word(req.word),
    .cnt(cnt),
    .spill_in(spill_flag),
    .fill_in(fill_bit),
    .res(core_res)
  );

  // ****************************************
  // Write back
  // ****************************************

  // Result word and spill flag, one cycle after start
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      result <= '{word: WORD_RST, spill: SPILL_RST};
      spill_flag <= SPILL_RST;
    end else if (start && !range_bad) begin
      // Both written back in one edge
      result <= core_res;
      spill_flag <= core_res.spill;
    end else if (start) begin
      // Refused request leaves word unchanged
      result <= '{word: req.word, spill: spill_flag};
    end
  end

  // Fill bit, written by the sequencer
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      fill_bit <= FILL_RST;
    end else if (fill_we) begin
      fill_bit <= fill_wdata;
    end
  end

  // Completion and error pulses
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      done <= 1'b0;
      amount_err <= 1'b0;
    end else begin
      done <= start;
      amount_err <= start && range_bad;
    end
  end

  // ****************************************
  // Checks
  // ****************************************

  a_done_follows: assert property (@(posedge clk) disable iff (!arst_n)
    start |=> done)
    else $error("done missing after start");

  a_zero_keep: assert property (@(posedge clk) disable iff (!arst_n)
    (start && cnt == 4'h0 && !range_bad) |=>
      (result.word == $past(req.word) && $stable(spill_flag)))
    else $error("zero count changed state");

  a_zfsr_top: assert property (@(posedge clk) disable iff (!arst_n)
    (start && !range_bad && req.op == zero_fill_shift_right
      && cnt != 4'h0) |=> !result.word[15])
    else $error("zero fill top bit set");

  a_zfsr_flag: assert property (@(posedge clk) disable iff (!arst_n)
    (start && !range_bad && req.op == zero_fill_shift_right
      && cnt != 4'h0) |=>
      spill_flag == $past(req.word[cnt - 4'h1]))
    else $error("zero fill flag wrong");

  a_shl_low: assert property (@(posedge clk) disable iff (!arst_n)
    (start && !range_bad && req.op == shift_left_fill
      && cnt != 4'h0) |=> result.word[0] == $past(fill_bit))
    else $error("left fill low bit wrong");

  a_shl_flag: assert property (@(posedge clk) disable iff (!arst_n)
    (start && !range_bad && req.op == shift_left_fill
      && cnt != 4'h0) |=>
      spill_flag == $past(req.word[4'hF - (cnt - 4'h1)]))
    else $error("left fill flag wrong");

  a_shr_top: assert property (@(posedge clk) disable iff (!arst_n)
    (start && !range_bad && req.op == shift_right_fill
      && cnt != 4'h0) |=> result.word[15] == $past(fill_bit))
    else $error("right fill top bit wrong");

  a_shr_flag: assert property (@(posedge clk) disable iff (!arst_n)
    (start && !range_bad && req.op == shift_right_fill
      && cnt != 4'h0) |=>
      spill_flag == $past(req.word[cnt - 4'h1]))
    else $error("right fill flag wrong");

  a_ror_top: assert property (@(posedge clk) disable iff (!arst_n)
    (start && !range_bad && req.op == rotate_right_thru_flag
      && cnt == 4'h1) |=>
      (result.word[15] == $past(spill_flag)
        && spill_flag == $past(req.word[0])))
    else $error("rotate right step wrong");

  a_rol_low: assert property (@(posedge clk) disable iff (!arst_n)
    (start && !range_bad && req.op == rotate_left_thru_flag
      && cnt == 4'h1) |=>
      (result.word[0] == $past(spill_flag)
        && spill_flag == $past(req.word[15])))
    else $error("rotate left step wrong");

  a_imm_range: assert property (@(posedge clk) disable iff (!arst_n)
    (start && range_bad) |=> (amount_err && $stable(spill_flag)))
    else $error("bad immediate not refused");

  a_rot_zero: assert property (@(posedge clk) disable iff (!arst_n)
    (start && !range_bad && cnt == 4'h0
      && req.op == rotate_left_thru_flag) |=>
      result.word == $past(req.word))
    else $error("zero rotate changed word");

  a_zf_zero: assert property (@(posedge clk) disable iff (!arst_n)
    (start && !range_bad && cnt == 4'h0
      && req.op == zero_fill_shift_right) |=> $stable(spill_flag))
    else $error("zero shift changed flag");

  // ****************************************
  // Handshake and hold checks
  // ****************************************

  a_done_single: assert property (
    @(posedge clk) disable iff (!arst_n)
    !start |=> !done)
    else $error("done without start");

  a_err_only_start: assert property (
    @(posedge clk) disable iff (!arst_n)
    !start |=> !amount_err)
    else $error("error pulse without start");

  a_result_hold: assert property (
    @(posedge clk) disable iff (!arst_n)
    !start |=> $stable(result))
    else $error("result moved while idle");

  a_spill_hold: assert property (
    @(posedge clk) disable iff (!arst_n)
    !start |=> $stable(spill_flag))
    else $error("spill flag moved while idle");

  a_spill_match: assert property (
    @(posedge clk) disable iff (!arst_n)
    start |=> (result.spill == spill_flag))
    else $error("result spill differs from flag");

  a_fill_write: assert property (
    @(posedge clk) disable iff (!arst_n)
    fill_we |=> (fill_bit == $past(fill_wdata)))
    else $error("fill bit write lost");

  a_fill_hold: assert property (
    @(posedge clk) disable iff (!arst_n)
    !fill_we |=> $stable(fill_bit))
    else $error("fill bit moved without write");

  // ****************************************
  // Count source checks
  // ****************************************

  a_mem_never_bad: assert property (
    @(posedge clk) disable iff (!arst_n)
    (start && !req.imm) |=> !amount_err)
    else $error("memory amount refused");

  a_imm_ok: assert property (
    @(posedge clk) disable iff (!arst_n)
    (start && req.imm && !range_bad) |=> !amount_err)
    else $error("legal immediate refused");

  a_refuse_word: assert property (
    @(posedge clk) disable iff (!arst_n)
    (start && range_bad) |=> (result.word == $past(req.word)))
    else $error("refused op changed word");

  // ****************************************
  // Whole-word shape checks, with the zero right fill flag check
  // ****************************************

  a_zfsr_shape: assert property (
    @(posedge clk) disable iff (!arst_n)
    (start && !range_bad && req.op == zero_fill_shift_right) |=>
      (result.word == ($past(req.word) >> $past(cnt))))
    else $error("zero fill word wrong");

  // Fifteen steps leave top bit only
  a_zfsr_15: assert property (
    @(posedge clk) disable iff (!arst_n)
    (start && !range_bad && req.op == zero_fill_shift_right
      && cnt == 4'hF) |=>
      (result.word == {15'h0000, $past(req.word[15])}
        && spill_flag == $past(req.word[14])))
    else $error("zero fill by fifteen wrong");

  a_shl_shape: assert property (
    @(posedge clk) disable iff (!arst_n)
    (start && !range_bad && req.op == shift_left_fill) |=>
      (result.word == (($past(req.word) << $past(cnt))
        | ($past(fill_bit) ? ~(16'hFFFF << $past(cnt)) : 16'h0000))))
    else $error("left fill word wrong");

  a_shr_shape: assert property (
    @(posedge clk) disable iff (!arst_n)
    (start && !range_bad && req.op == shift_right_fill) |=>
      (result.word == (($past(req.word) >> $past(cnt))
        | ($past(fill_bit) ? ~(16'hFFFF >> $past(cnt)) : 16'h0000))))
    else $error("right fill word wrong");

  a_shr_zero: assert property (
    @(posedge clk) disable iff (!arst_n)
    (start && !range_bad && cnt == 4'h0
      && req.op == shift_right_fill) |=> $stable(spill_flag))
    else $error("zero right fill changed flag");

  a_ror_zero: assert property (
    @(posedge clk) disable iff (!arst_n)
    (start && !range_bad && cnt == 4'h0
      && req.op == rotate_right_thru_flag) |=>
      (result.word == $past(req.word) && $stable(spill_flag)))
    else $error("zero rotate right changed state");

  a_ror_shape: assert property (
    @(posedge clk) disable iff (!arst_n)
    (start && !range_bad && req.op == rotate_right_thru_flag
      && cnt == 4'h1) |=>
      (result.word == {$past(spill_flag), $past(req.word[15:1])}))
    else $error("rotate right word wrong");

  a_rol_shape: assert property (
    @(posedge clk) disable iff (!arst_n)
    (start && !range_bad && req.op == rotate_left_thru_flag
      && cnt == 4'h1) |=>
      (result.word == {$past(req.word[14:0]), $past(spill_flag)}))
    else $error("rotate left word wrong");

endmodule : word_shift_rotate_unit

//--- rtl/wsr_core.sv
// Combinational shift and rotate core
`timescale 1ns/100ps
module wsr_core
  import wsr_pkg::*;
(
  input wire op_t op,
  input wire logic [15:0] word,
  input wire logic [3:0] cnt,
  input wire logic spill_in,
  input wire logic fill_in,
  output res_t res
);

  // Result of one 17-bit step per count, unrolled by a bounded loop
  always_comb begin
    logic [15:0] w;
    logic c;
    w = word;
    c = spill_in;
    // Sixteen passes so that a count of fifteen takes all fifteen steps
    for (int i = 0; i < 16; i++) begin
      if (i < int'(cnt)) begin
        unique case (op)
          shift_left_fill: begin
            c = w[15];
            w = {w[14:0], fill_in};
          end
          shift_right_fill: begin
            c = w[0];
            w = {fill_in, w[15:1]};
          end
          // Flag to top, low bit to flag
          rotate_right_thru_flag: begin
            {w, c} = {c, w};
          end
          // Flag to low, top bit to flag
          rotate_left_thru_flag: begin
            {c, w} = {w, c};
          end
          // Last bit out goes to flag
          zero_fill_shift_right: begin
            c = w[0];
            w = {1'b0, w[15:1]};
          end
          default: begin
            c = c;
          end
        endcase
      end
    end
    // Zero count keeps word and flag
    res.word = w;
    res.spill = c;
  end

endmodule : wsr_core

//--- rtl/wsr_pkg.sv
// Package: constants and types for the word shift and rotate unit
package wsr_pkg;

  // Word and count widths
  localparam int WORD_W = 16;
  localparam int CNT_W = 4;

  // Reset values of the held word, spill flag and fill bit
  localparam logic [15:0] WORD_RST = 16'h0000;
  localparam logic SPILL_RST = 1'b0;
  localparam logic FILL_RST = 1'b0;

  // Internal output addresses of the two flags (informative)
  localparam logic [11:0] SPILL_ADDR = 12'h07F0;
  localparam logic [11:0] FILL_ADDR = 12'h07F2;

  // Operation codes
  typedef enum logic [2:0] {
    shift_left_fill = 3'h0,
    shift_right_fill = 3'h1,
    rotate_right_thru_flag = 3'h2,
    rotate_left_thru_flag = 3'h3,
    zero_fill_shift_right = 3'h4
  } op_t;

  // Request carried from the sequencer
  typedef struct packed {
    op_t op;
    logic [15:0] word;
    logic [15:0] amount;
    logic imm;
  } req_t;

  // Result carried back
  typedef struct packed {
    logic [15:0] word;
    logic spill;
  } res_t;

endpackage : wsr_pkg

//--- verif/sequencer_model.sv
// Sequencer model: issues shift requests and fill writes to the unit
`timescale 1ns/100ps
module sequencer_model
  import wsr_pkg::*;
(
  input wire logic clk,
  input wire logic done,
  input wire logic amount_err,
  input wire res_t result,
  output req_t req,
  output logic start,
  output logic fill_we,
  output logic fill_wdata
);
  // Idle request lines at time zero
  initial begin
    start = 1'b0;
    req = '0;
    fill_we = 1'b0;
    fill_wdata = 1'b0;
  end

  // One op: strobe for one cycle, then wait a bounded time for done
  task automatic run_op(input op_t op, input logic [15:0] w, input logic [15:0] amt,
                        input logic imm, output res_t r, output logic err,
                        output logic ok);
    int k;
    @(negedge clk);
    start = 1'b1;
    req = '{op, w, amt, imm};
    @(negedge clk);
    start = 1'b0;
    // Released operand lines show junk, not the last value
    req = ~req;
    ok = 1'b0;
    for (k = 0; k < 4 && !ok; k++) begin
      if (done === 1'b1) begin
        ok = 1'b1;
        r = result;
        err = amount_err;
      end else begin
        @(negedge clk);
      end
    end
  endtask : run_op

  // Fill bit write pulse
  task automatic set_fill(input logic v);
    @(negedge clk);
    fill_we = 1'b1;
    fill_wdata = v;
    @(negedge clk);
    fill_we = 1'b0;
    fill_wdata = ~v;
  endtask : set_fill
endmodule : sequencer_model

//--- verif/testbench.sv
// Testbench: sweeps every op and count against a bit-serial model
`timescale 1ns/100ps
module testbench;
  import wsr_pkg::*;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic start, fill_we, fill_wdata, done, amount_err, spill_flag, fill_bit;
  req_t req;
  res_t result;
  int mismatches = 0;
  int tests_run = 0;
  // Expected spill flag and fill bit, tracked across ops
  logic exp_c = 1'b0;
  logic exp_f = 1'b0;

  word_shift_rotate_unit i_dut (.clk(clk), .arst_n(arst_n), .start(start),
    .req(req), .fill_we(fill_we), .fill_wdata(fill_wdata), .result(result),
    .done(done), .amount_err(amount_err), .spill_flag(spill_flag),
    .fill_bit(fill_bit));
  sequencer_model i_seq (.clk(clk), .done(done), .amount_err(amount_err),
    .result(result), .req(req), .start(start), .fill_we(fill_we),
    .fill_wdata(fill_wdata));

  always #5 clk = ~clk;

  task automatic chk(input string name, input logic [16:0] seen, input logic [16:0] exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  task automatic conclude();
    $display("mismatches %0d tests_run %0d", mismatches, tests_run);
    if (mismatches == 0 && tests_run > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : conclude

  // One step at a time, so the flag chain is modelled literally
  function automatic logic [16:0] ref_op(op_t op, logic [15:0] w, logic [3:0] n,
                                         logic c, logic f);
    for (int i = 0; i < n; i++) begin
      case (op)
        shift_left_fill: {c, w} = {w, f};
        shift_right_fill: {w, c} = {f, w};
        rotate_right_thru_flag: {w, c} = {c, w};
        rotate_left_thru_flag: {c, w} = {w, c};
        default: {w, c} = {1'b0, w};
      endcase
    end
    return {w, c};
  endfunction : ref_op

  // Issue one op and judge word, flag and refusal pulse
  task automatic op_chk(input op_t op, input logic [15:0] w, input logic [15:0] amt,
                        input logic imm);
    res_t r;
    logic err, ok, bad;
    logic [16:0] e;
    bad = imm && (amt[15:4] != 12'h000);
    e = bad ? {w, exp_c} : ref_op(op, w, amt[3:0], exp_c, exp_f);
    i_seq.run_op(op, w, amt, imm, r, err, ok);
    if (!ok) begin
      mismatches++;
      conclude();
    end
    chk("result", r, e);
    chk("spill_flag", 17'(spill_flag), 17'(e[0]));
    chk("amount_err", 17'(err), 17'(bad));
    exp_c = e[0];
  endtask : op_chk

  // Given op, both fill values, every count, memory and immediate forms
  task automatic t_sweep(input op_t op);
    for (int f = 0; f < 2; f++) begin
      i_seq.set_fill(f[0]);
      exp_f = f[0];
      chk("fill_bit", 17'(fill_bit), 17'(exp_f));
      for (int n = 0; n < 16; n++) begin
        op_chk(op, 16'h5678 ^ 16'(n * 16'h0911),
               {12'hFF0, 4'(n)}, 1'b0);
        op_chk(op, 16'h1234 + 16'(n), 16'(n), 1'b1);
      end
    end
  endtask : t_sweep

  initial begin
    repeat (5) @(negedge clk);
    arst_n = 1'b1;
    chk("reset", {result.word, spill_flag}, 17'h0_0000);
    for (int o = 0; o < 5; o++) begin
      t_sweep(op_t'(o));
    end
    // Immediate counts above fifteen are refused
    op_chk(shift_left_fill, 16'hA5A5, 16'h0010, 1'b1);
    op_chk(rotate_left_thru_flag, 16'h0F0F, 16'hFFFF, 1'b1);
    conclude();
  end
endmodule : testbench
